// file: hdl/flash_crc_checker.sv
// Flash CRC memory scanner with APB register slave
// Function
// - CRC-16 with x16+x12+x5+1 polynomial
// - Checksum preset to all ones per scan
// - Bytes from zero, shifted MSB first
// - Pass flag follows comparison at scan end
// - Scan starts three cycles after enable
// - Scan stalls CPU in every mode, fetch every third
// - Fuse requests scan before reset release
// - Reset scan leaves enable, source, pass visible
// - Failure interrupt enable set-only until reset
// - Failure with enable raises sticky interrupt
// - Interrupt ignores global interrupt enable
// - Scan halts in sleep, resumes on wake
// - Sleep in start delay defers scan
// - Debugger access disables, restart on release
// - Busy stays while debugger-disabled, no progress
// - Debugger busy write aborts or queues scan
// - Busy locks mode, source, interrupt enable
// - Debugger pass clear fires interrupt, locks writes
// - Debugger pass write one reads one idle
// - Debugger control writes act as CPU writes
// - Section codes whole, boot+app, boot, reserved
// - Soft reset clears registers except interrupt enable next cycle; refused if busy with it set
// - Pass flag reads one before any scan
// - Enable stays one, rewrite restarts, zero ignored
`timescale 1ns/1ns
module flash_crc_checker
   import crc_scan_pkg::*;
#(
   parameter int AW = 16
) (
   // Clock and reset
   input  wire logic          REF_CLK,
   input  wire logic          RST,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [11:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   // Debugger
   input  wire logic          DBG_WRITE,
   input  wire logic          DBG_ACCESS,
   input  wire logic          DBG_RELEASE,
   // Power
   input  wire logic          SLEEP,
   // Fuses
   input  wire logic          FUSE_SCAN_EN,
   input  wire logic [1:0]    FUSE_SCAN_SEC,
   input  wire logic [7:0]    BOOT_END_FUSE,
   input  wire logic [7:0]    APP_END_FUSE,
   // Flash array
   output logic               FLASH_RD,
   output logic      [AW-1:0] FLASH_ADDR,
   input  wire logic [15:0]   FLASH_RDATA,
   // CPU
   output logic               CPU_STALL,
   output logic               CPU_HOLD,
   output logic               NMI_REQ
);
   if (AW < 16 || AW > 24) begin : g_aw_chk
      $error("AW must lie in 16..24");
   end

   localparam logic [1:0] DLY_LAST = 2'(START_DLY - 1);
   localparam logic [1:0] DIV_LAST = 2'(FETCH_DIV - 1);

   scan_state_t   state_r;
   scan_cfg_t     cfg_r;
   logic          ok_r;
   logic          nmi_r;
   logic          dbg_off_r;
   logic          restart_r;
   logic          srst_r;
   logic          boot_pend_r;
   logic          boot_r;
   logic          slept_r;
   logic [1:0]    dcnt_r;
   logic [1:0]    div_r;
   logic [AW-1:0] ptr_r;
   logic [AW-1:0] end_r;
   logic          last_sent_r;
   logic          rd_last_r;
   logic          dvalid_r;
   logic          dlast_r;
   logic [15:0]   crc_w;
   logic [15:0]   stored_w;
   logic [31:0]   rdata_w;
   logic          busy_w;
   logic          halt_w;
   logic          acc_w;
   logic          wr_w;
   logic          wr_ctrl_w;
   logic          wr_mode_w;
   logic          wr_stat_w;
   logic          start_w;
   logic          dbg_go_w;
   logic          abort_w;
   logic          go_w;
   logic          boot_go_w;
   logic          enter_w;
   logic          issue_w;
   logic          load_w;
   logic          fin_w;
   logic          match_w;
   logic          dbg_ok0_w;
   logic          mapped_w;

   function automatic logic reg_hit(input logic [APB_AW-1:0] a, input int idx);
      return a == APB_AW'(idx * REG_STRIDE);
   endfunction : reg_hit

   function automatic logic [AW-1:0] sect_end(input logic [1:0] s);
      case (s)
         SEC_BOOT:    return (AW'(BOOT_END_FUSE) << SECT_SHIFT) - AW'(1);
         SEC_BOOT_PLUS_APP_SELECT: return (AW'(APP_END_FUSE) << SECT_SHIFT) - AW'(1);
         default:     return {AW{1'b1}};
      endcase
   endfunction : sect_end

   // Bus decode; writes refused once the interrupt fired
   assign acc_w     = PSEL & PENABLE & PREADY;
   assign wr_w      = acc_w & PWRITE & !nmi_r;
   assign wr_ctrl_w = wr_w & reg_hit(PADDR, IDX_CTRL);
   assign wr_mode_w = wr_w & reg_hit(PADDR, IDX_MODE);
   assign wr_stat_w = wr_w & reg_hit(PADDR, IDX_STAT) & DBG_WRITE;
   assign mapped_w  = reg_hit(PADDR, IDX_CTRL) | reg_hit(PADDR, IDX_MODE) | reg_hit(PADDR, IDX_STAT);

   assign busy_w    = state_r != ST_IDLE;
   assign halt_w    = SLEEP | dbg_off_r;
   assign start_w   = wr_ctrl_w & PWDATA[B_EN] & !busy_w;
   assign dbg_go_w  = wr_stat_w & PWDATA[B_BUSY] & !busy_w;
   assign abort_w   = (wr_stat_w & !PWDATA[B_BUSY]) | srst_r;
   assign go_w      = start_w | dbg_go_w | (DBG_RELEASE & restart_r & busy_w);
   assign boot_go_w = boot_pend_r & FUSE_SCAN_EN;
   assign enter_w   = boot_go_w | (state_r == ST_DELAY && !halt_w && dcnt_r == DLY_LAST);
   assign issue_w   = state_r == ST_SCAN && !halt_w && !last_sent_r && div_r == DIV_LAST;
   assign load_w    = state_r == ST_SCAN && dvalid_r && !dlast_r;
   assign fin_w     = state_r == ST_SCAN && dvalid_r && dlast_r;
   // High checksum byte sits at the lower address
   assign stored_w  = {FLASH_RDATA[7:0], FLASH_RDATA[15:8]};
   assign match_w   = crc_w == stored_w;
   assign dbg_ok0_w = wr_stat_w & !PWDATA[B_OK];

   crc16_unit u_crc (
      .clk  (REF_CLK),
      .rst  (RST),
      .init (enter_w),
      .load (load_w),
      .word (FLASH_RDATA),
      .crc  (crc_w)
   );

   // Sequencer
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         dcnt_r  <= 2'h0;
      end else if (abort_w) begin
         state_r <= ST_IDLE;
      end else if (enter_w) begin
         state_r <= ST_SCAN;
      end else if (go_w) begin
         state_r <= ST_DELAY;
         dcnt_r  <= 2'h0;
      end else if (fin_w) begin
         state_r <= ST_IDLE;
      end else if (state_r == ST_DELAY && !halt_w) begin
         dcnt_r <= dcnt_r + 2'h1;
      end
   end

   // Fetch pacing and address walk
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         FLASH_RD    <= 1'b0;
         FLASH_ADDR  <= '0;
         ptr_r       <= '0;
         end_r       <= '0;
         div_r       <= 2'h0;
         last_sent_r <= 1'b0;
         rd_last_r   <= 1'b0;
         dvalid_r    <= 1'b0;
         dlast_r     <= 1'b0;
      end else begin
         FLASH_RD  <= issue_w;
         rd_last_r <= issue_w && ptr_r == end_r - AW'(1);
         dvalid_r  <= FLASH_RD;
         dlast_r   <= rd_last_r;
         if (enter_w) begin
            ptr_r       <= '0;
            div_r       <= 2'h0;
            last_sent_r <= 1'b0;
            end_r       <= sect_end(boot_go_w ? FUSE_SCAN_SEC : cfg_r.src);
         end else if (state_r == ST_SCAN && !halt_w && !last_sent_r) begin
            div_r <= (div_r == DIV_LAST) ? 2'h0 : div_r + 2'h1;
            if (issue_w) begin
               FLASH_ADDR  <= ptr_r;
               ptr_r       <= ptr_r + AW'(2);
               last_sent_r <= ptr_r == end_r - AW'(1);
            end
         end
      end
   end

   // Debugger disable and restart tracking
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         dbg_off_r <= 1'b0;
         restart_r <= 1'b0;
      end else begin
         dbg_off_r <= DBG_ACCESS | (dbg_off_r & !DBG_RELEASE);
         restart_r <= (DBG_ACCESS & busy_w) | (restart_r & !DBG_RELEASE & !abort_w);
      end
   end

   // Control registers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cfg_r  <= CFG_RST;
         srst_r <= 1'b0;
      end else begin
         srst_r <= wr_ctrl_w & PWDATA[B_SRST] & (!cfg_r.fail_interrupt_enable | !busy_w);
         if (boot_go_w) begin
            cfg_r.enable <= 1'b1;
            cfg_r.src    <= FUSE_SCAN_SEC;
         end else if (srst_r) begin
            cfg_r.enable <= 1'b0;
            cfg_r.mode   <= 2'h0;
            cfg_r.src    <= 2'h0;
         end else begin
            if (wr_ctrl_w && PWDATA[B_EN]) begin
               cfg_r.enable <= 1'b1;
            end
            if (wr_ctrl_w && PWDATA[B_FAIL_INTERRUPT_ENABLE] && !busy_w) begin
               cfg_r.fail_interrupt_enable <= 1'b1;
            end
            if (wr_mode_w && !busy_w) begin
               cfg_r.mode <= PWDATA[F_MODE+:2];
               cfg_r.src  <= PWDATA[F_SRC+:2];
            end
         end
      end
   end

   // Pass flag and failure interrupt
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ok_r    <= OK_RST;
         nmi_r   <= 1'b0;
         NMI_REQ <= 1'b0;
      end else begin
         if (srst_r) begin
            ok_r <= 1'b0;
         end else if (fin_w) begin
            ok_r <= match_w;
         end else if (dbg_ok0_w) begin
            ok_r <= 1'b0;
         end else if (wr_stat_w && !busy_w) begin
            ok_r <= 1'b1;
         end
         // Sticky, independent of any global enable
         // Scan result beats a debugger clear, so no request without a cleared flag
         if (cfg_r.fail_interrupt_enable && !srst_r && ((fin_w && !match_w) || (dbg_ok0_w && !fin_w))) begin
            nmi_r   <= 1'b1;
            NMI_REQ <= 1'b1;
         end
      end
   end

   // Reset-time scan and CPU control
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         boot_pend_r <= 1'b1;
         boot_r      <= 1'b0;
         slept_r     <= 1'b0;
         CPU_HOLD    <= 1'b1;
         CPU_STALL   <= 1'b0;
      end else begin
         boot_pend_r <= 1'b0;
         if (boot_go_w) begin
            boot_r <= 1'b1;
         end else if (fin_w) begin
            boot_r <= 1'b0;
         end
         if (boot_pend_r && !FUSE_SCAN_EN) begin
            CPU_HOLD <= 1'b0;
         end else if (fin_w && boot_r) begin
            CPU_HOLD <= !match_w;
         end
         if (state_r == ST_DELAY && SLEEP) begin
            slept_r <= 1'b1;
         end else if (state_r == ST_IDLE) begin
            slept_r <= 1'b0;
         end
         // Handlers wait if sleep hit the start delay
         CPU_STALL <= state_r == ST_SCAN || (state_r == ST_DELAY && (slept_r || SLEEP));
      end
   end

   // Register read view
   always_comb begin
      rdata_w = 32'h0000_0000;
      if (reg_hit(PADDR, IDX_CTRL)) begin
         rdata_w[B_EN]    = cfg_r.enable;
         rdata_w[B_FAIL_INTERRUPT_ENABLE] = cfg_r.fail_interrupt_enable;
      end else if (reg_hit(PADDR, IDX_MODE)) begin
         rdata_w[F_MODE+:2] = cfg_r.mode;
         rdata_w[F_SRC+:2]  = cfg_r.src;
      end else if (reg_hit(PADDR, IDX_STAT)) begin
         rdata_w[B_OK]   = ok_r;
         rdata_w[B_BUSY] = busy_w;
      end
   end

   // APB answer after one wait state
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & PENABLE & !PREADY;
         PSLVERR <= PSEL & PENABLE & !PREADY & !mapped_w;
         if (PSEL && PENABLE && !PREADY) begin
            PRDATA <= rdata_w;
         end
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_start;
      start_w ##1 (!halt_w && !abort_w)[*3];
   endsequence
   property p_start_dly;
      s_start |=> state_r == ST_SCAN;
   endproperty
   a_start_dly: assert property (p_start_dly) else $error("Scan start delay wrong");

   property p_fetch_gap;
      FLASH_RD |=> !FLASH_RD [*2];
   endproperty
   a_fetch_gap: assert property (p_fetch_gap) else $error("Fetch closer than three cycles");

   property p_halt;
      halt_w |=> !FLASH_RD;
   endproperty
   a_halt: assert property (p_halt) else $error("Fetch while halted");

   property p_nmi_sticky;
      NMI_REQ |=> NMI_REQ;
   endproperty
   a_nmi_sticky: assert property (p_nmi_sticky) else $error("Interrupt request dropped");

   property p_nmi_cause;
      $rose(NMI_REQ) |-> cfg_r.fail_interrupt_enable && !ok_r;
   endproperty
   a_nmi_cause: assert property (p_nmi_cause) else $error("Interrupt without failure");

   property p_fail_interrupt_enable;
      cfg_r.fail_interrupt_enable |=> cfg_r.fail_interrupt_enable;
   endproperty
   a_fail_interrupt_enable: assert property (p_fail_interrupt_enable) else $error("Interrupt enable cleared");

   property p_busy_lock;
      wr_mode_w && busy_w |=> $stable(cfg_r.src) && $stable(cfg_r.mode);
   endproperty
   a_busy_lock: assert property (p_busy_lock) else $error("Mode written while busy");

   property p_result;
      fin_w && !srst_r |=> ok_r == $past(match_w);
   endproperty
   a_result: assert property (p_result) else $error("Pass flag wrong");

   property p_nmi_lock;
      nmi_r && acc_w && PWRITE |=> $stable(cfg_r);
   endproperty
   a_nmi_lock: assert property (p_nmi_lock) else $error("Write after interrupt");

   sequence s_srst;
      wr_ctrl_w && PWDATA[B_SRST] && (!cfg_r.fail_interrupt_enable || !busy_w) ##1 srst_r;
   endsequence
   property p_srst;
      s_srst |=> !cfg_r.enable && !busy_w && !ok_r;
   endproperty
   a_srst: assert property (p_srst) else $error("Soft reset incomplete");
endmodule : flash_crc_checker

// file: hdl/crc_scan_pkg.sv
// Constants and types shared by the flash CRC scanner
package crc_scan_pkg;
   // Register indices; byte address is index times stride
   localparam int IDX_CTRL   = 0;
   localparam int IDX_MODE   = 1;
   localparam int IDX_STAT   = 2;
   localparam int REG_STRIDE = 4;
   localparam int APB_AW     = 12;
   // Field positions
   localparam int B_EN    = 0;
   localparam int B_FAIL_INTERRUPT_ENABLE = 1;
   localparam int B_SRST  = 7;
   localparam int B_BUSY  = 0;
   localparam int B_OK    = 1;
   localparam int F_SRC   = 0;
   localparam int F_MODE  = 4;
   // Section select codes
   localparam logic [1:0] SEC_FLASH   = 2'h0;
   localparam logic [1:0] SEC_BOOT_PLUS_APP_SELECT = 2'h1;
   localparam logic [1:0] SEC_BOOT    = 2'h2;
   // CRC definition
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   // Timing in main clock cycles, section unit as shift
   localparam int START_DLY  = 3;
   localparam int FETCH_DIV  = 3;
   localparam int SECT_SHIFT = 8;
   localparam logic OK_RST   = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DELAY = 2'b01,
      ST_SCAN  = 2'b11
   } scan_state_t;

   typedef struct packed {
      logic       fail_interrupt_enable;
      logic       enable;
      logic [1:0] mode;
      logic [1:0] src;
   } scan_cfg_t;

   localparam scan_cfg_t CFG_RST = 6'h00;
endpackage : crc_scan_pkg

// file: hdl/crc16_unit.sv
// CRC-16 engine taking one flash word as two bytes
`timescale 1ns/1ns
module crc16_unit
   import crc_scan_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Control and data
   input  wire logic        init,
   input  wire logic        load,
   input  wire logic [15:0] word,
   output logic      [15:0] crc
);
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] v;
      logic        fb;
      v = c;
      for (int i = 7; i >= 0; i--) begin
         fb = v[15] ^ b[i];
         v = {v[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return v;
   endfunction : crc_byte

   always_ff @(posedge clk) begin
      if (rst || init) begin
         crc <= CRC_INIT;
      end else if (load) begin
         // Lower address byte first
         crc <= crc_byte(crc_byte(crc, word[7:0]), word[15:8]);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_preset;
      init |=> crc == CRC_INIT;
   endproperty
   a_preset: assert property (p_preset) else $error("CRC not preset");

   property p_poly;
      load && !init && crc == 16'h0000 && word == 16'h0001 |=> crc == 16'h3331;
   endproperty
   a_poly: assert property (p_poly) else $error("CRC polynomial wrong");
endmodule : crc16_unit

// file: tb/flash_model.sv
// Behavioural flash array answering word fetches one cycle later
`timescale 1ns/1ns
module flash_model #(
   parameter int AW = 16
) (
   // Clock
   input  wire logic          clk,
   // Fetch port
   input  wire logic          rd,
   input  wire logic [AW-1:0] addr,
   output logic      [15:0]   rdata
);
   logic [7:0] mem [0:1023];

   // Low byte from even address; toggling filler when not fetched
   always_ff @(posedge clk) begin
      if (rd) begin
         rdata <= {mem[addr[9:0] | 10'h001], mem[addr[9:0]]};
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : flash_model

// file: tb/tb_top.sv
// Self-checking bench for the flash CRC scanner
`timescale 1ns/1ns
module tb_top
   import crc_scan_pkg::*;
;
   typedef struct packed {
      logic       wr;
      logic [1:0] idx;
      logic [7:0] d;
      logic [7:0] exp;
   } row_t;
   localparam row_t ROWS [11] = '{
      '{1'b0, 2'h0, 8'h00, 8'h00}, '{1'b0, 2'h1, 8'h00, 8'h00}, '{1'b0, 2'h2, 8'h00, 8'h02},
      '{1'b1, 2'h1, 8'h01, 8'h00}, '{1'b0, 2'h1, 8'h00, 8'h01}, '{1'b1, 2'h1, 8'h00, 8'h00},
      '{1'b0, 2'h1, 8'h00, 8'h00}, '{1'b1, 2'h1, 8'h02, 8'h00}, '{1'b0, 2'h1, 8'h00, 8'h02},
      '{1'b1, 2'h0, 8'h00, 8'h00}, '{1'b0, 2'h0, 8'h00, 8'h00}};
   logic        REF_CLK, RST, PSEL, PENABLE, PWRITE, DBG_WRITE, DBG_ACCESS, DBG_RELEASE, SLEEP;
   logic        FUSE_SCAN_EN, PREADY, PSLVERR, FLASH_RD, CPU_STALL, CPU_HOLD, NMI_REQ, e;
   logic [1:0]  FUSE_SCAN_SEC;
   logic [7:0]  BOOT_END_FUSE, APP_END_FUSE;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, v;
   logic [15:0] FLASH_ADDR, FLASH_RDATA, last_addr;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0, n_rd = 0, n0, k;

   flash_crc_checker #(.AW(16)) dut_u (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .DBG_WRITE(DBG_WRITE), .DBG_ACCESS(DBG_ACCESS), .DBG_RELEASE(DBG_RELEASE),
      .SLEEP(SLEEP), .FUSE_SCAN_EN(FUSE_SCAN_EN), .FUSE_SCAN_SEC(FUSE_SCAN_SEC),
      .BOOT_END_FUSE(BOOT_END_FUSE), .APP_END_FUSE(APP_END_FUSE), .FLASH_RD(FLASH_RD),
      .FLASH_ADDR(FLASH_ADDR), .FLASH_RDATA(FLASH_RDATA), .CPU_STALL(CPU_STALL),
      .CPU_HOLD(CPU_HOLD), .NMI_REQ(NMI_REQ));
   flash_model #(.AW(16)) mdl_u (.clk(REF_CLK), .rd(FLASH_RD), .addr(FLASH_ADDR), .rdata(FLASH_RDATA));

   initial begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end

   // Fetch monitor and run limit
   always @(posedge REF_CLK) begin
      cyc++;
      if (FLASH_RD === 1'b1) begin
         n_rd <= n_rd + 1;
         last_addr <= FLASH_ADDR;
      end
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   task automatic tick(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask : tick

   task automatic apb(input logic wr, input logic [1:0] idx, input logic [7:0] d, input logic dbg);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= {8'h00, idx, 2'h0};
      PWDATA <= {24'h000000, d};
      DBG_WRITE <= dbg;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do @(posedge REF_CLK); while (PREADY !== 1'b1);
      v = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      DBG_WRITE <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [1:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, 1'b0);
      chk(v, {24'h000000, exp});
   endtask : rdchk

   task automatic wait_idle();
      int t;
      t = 0;
      do begin
         apb(1'b0, 2'h2, 8'h00, 1'b0);
         t++;
      end while (v[0] !== 1'b0 && t < 3000);
   endtask : wait_idle

   // Completion: fetch count, last word address and status
   task automatic fin(input int words, input logic [7:0] stat);
      wait_idle();
      chk(32'(n_rd - n0), 32'(words));
      chk({16'h0000, last_addr}, 32'(2 * words - 2));
      rdchk(2'h2, stat);
   endtask : fin

   // Stores the CRC of all but the last two bytes, high byte first
   task automatic seal(input int n);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < n - 2; i++) begin
         for (int b = 7; b >= 0; b--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ mdl_u.mem[i][b]) ? CRC_POLY : 16'h0000);
         end
      end
      mdl_u.mem[n - 2] = c[15:8];
      mdl_u.mem[n - 1] = c[7:0];
   endtask : seal

   task automatic do_reset();
      RST <= 1'b1;
      tick(6);
      RST <= 1'b0;
      tick(1);
   endtask : do_reset

   initial begin
      {RST, PSEL, PENABLE, PWRITE, DBG_WRITE, DBG_ACCESS, DBG_RELEASE, SLEEP, FUSE_SCAN_EN} = 9'h100;
      PADDR = 12'h000;
      PWDATA = 32'h00000000;
      FUSE_SCAN_SEC = 2'h2;
      BOOT_END_FUSE = 8'h01;
      APP_END_FUSE = 8'h02;
      for (int i = 0; i < 1024; i++) mdl_u.mem[i] = 8'(i * 7 + 1);
      seal(256);
      seal(512);
      do_reset();
      for (int i = 0; i < 11; i++) begin
         if (ROWS[i].wr) apb(1'b1, ROWS[i].idx, ROWS[i].d, 1'b0);
         else rdchk(ROWS[i].idx, ROWS[i].exp);
      end
      apb(1'b0, 2'h3, 8'h00, 1'b0);
      chk(e, 1'b1);
      $display("test registers done");
      n0 = n_rd;
      apb(1'b1, 2'h0, 8'h01, 1'b0);
      k = 0;
      do begin
         @(posedge REF_CLK);
         k++;
         if (k == 2) chk(CPU_STALL, 1'b0);
      end while (FLASH_RD !== 1'b1 && k < 50);
      chk(k, 7);
      chk(FLASH_ADDR, 0);
      chk(CPU_STALL, 1'b1);
      k = 0;
      do begin
         @(posedge REF_CLK);
         k++;
      end while (FLASH_RD !== 1'b1 && k < 10);
      chk(k, 3);
      chk(FLASH_ADDR, 2);
      apb(1'b1, 2'h1, 8'h01, 1'b0);
      apb(1'b1, 2'h0, 8'h02, 1'b0);
      rdchk(2'h1, 8'h02);
      rdchk(2'h0, 8'h01);
      fin(128, 8'h02);
      rdchk(2'h0, 8'h01);
      apb(1'b1, 2'h1, 8'h01, 1'b0);
      n0 = n_rd;
      apb(1'b1, 2'h0, 8'h01, 1'b0);
      fin(256, 8'h02);
      apb(1'b1, 2'h1, 8'h02, 1'b0);
      $display("test scans done");
      n0 = n_rd;
      apb(1'b1, 2'h0, 8'h01, 1'b0);
      SLEEP <= 1'b1;
      tick(20);
      chk(32'(n_rd - n0), 0);
      chk(CPU_STALL, 1'b1);
      SLEEP <= 1'b0;
      tick(150);
      SLEEP <= 1'b1;
      tick(2);
      k = n_rd;
      tick(30);
      chk(n_rd, k);
      SLEEP <= 1'b0;
      fin(128, 8'h02);
      $display("test sleep done");
      apb(1'b1, 2'h0, 8'h01, 1'b1);
      tick(60);
      DBG_ACCESS <= 1'b1;
      @(posedge REF_CLK);
      DBG_ACCESS <= 1'b0;
      tick(2);
      k = n_rd;
      tick(30);
      chk(n_rd, k);
      apb(1'b0, 2'h2, 8'h00, 1'b0);
      chk(v[0], 1'b1);
      DBG_RELEASE <= 1'b1;
      @(posedge REF_CLK);
      DBG_RELEASE <= 1'b0;
      n0 = k;
      fin(128, 8'h02);
      n0 = n_rd;
      apb(1'b1, 2'h2, 8'h01, 1'b1);
      fin(128, 8'h02);
      apb(1'b1, 2'h2, 8'h01, 1'b1);
      tick(30);
      apb(1'b1, 2'h2, 8'h00, 1'b1);
      tick(3);
      k = n_rd;
      tick(30);
      chk(n_rd, k);
      apb(1'b1, 2'h2, 8'h00, 1'b1);
      rdchk(2'h2, 8'h00);
      chk(NMI_REQ, 1'b0);
      apb(1'b1, 2'h2, 8'h02, 1'b1);
      rdchk(2'h2, 8'h02);
      $display("test debug done");
      apb(1'b1, 2'h1, 8'h01, 1'b0);
      apb(1'b1, 2'h0, 8'h01, 1'b0);
      tick(20);
      apb(1'b1, 2'h0, 8'h80, 1'b0);
      tick(2);
      rdchk(2'h0, 8'h00);
      rdchk(2'h1, 8'h00);
      rdchk(2'h2, 8'h00);
      apb(1'b1, 2'h1, 8'h02, 1'b0);
      mdl_u.mem[10] = mdl_u.mem[10] ^ 8'h01;
      apb(1'b1, 2'h0, 8'h02, 1'b0);
      apb(1'b1, 2'h0, 8'h00, 1'b0);
      rdchk(2'h0, 8'h02);
      n0 = n_rd;
      apb(1'b1, 2'h0, 8'h03, 1'b0);
      fin(128, 8'h00);
      chk(NMI_REQ, 1'b1);
      apb(1'b1, 2'h1, 8'h01, 1'b0);
      apb(1'b1, 2'h0, 8'h80, 1'b0);
      rdchk(2'h1, 8'h02);
      rdchk(2'h0, 8'h03);
      $display("test failure done");
      FUSE_SCAN_EN <= 1'b1;
      do_reset();
      chk(CPU_HOLD, 1'b1);
      tick(2);
      wait_idle();
      tick(3);
      chk(CPU_HOLD, 1'b1);
      chk(NMI_REQ, 1'b0);
      rdchk(2'h2, 8'h00);
      rdchk(2'h1, 8'h02);
      mdl_u.mem[10] = mdl_u.mem[10] ^ 8'h01;
      do_reset();
      tick(2);
      wait_idle();
      tick(3);
      chk(CPU_HOLD, 1'b0);
      rdchk(2'h2, 8'h02);
      rdchk(2'h0, 8'h01);
      $display("test reset scan done");
      wrap_up();
   end
endmodule : tb_top
